//--- pipeline_model.sv
/*
  Model of the core pipeline facing the vectoring block: holds trap causes
  until trap_ack and supplies the trap table base.
  Assumes: the bench calls raise at a rising clk edge while the block is idle.
*/
`timescale 1ns/100ps
`default_nettype none

module pipeline_model #(
  parameter logic [31:0] TVB = 32'h0000_4000
) (
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        trap_ack,
  output logic      [31:0] trap_vector_base,
  output logic      [1:0]  mmu_cause,
  output logic      [6:0]  prot_cause,
  output logic      [4:0]  instr_cause,
  output logic      [6:0]  ctx_cause,
  output logic      [5:0]  bus_cause,
  output logic      [1:0]  assert_cause,
  output logic             system_call_instruction_req,
  output logic      [7:0]  system_call_instruction_imm,
  output logic             nmi_req
);
  logic [30:0] causes;
  logic [7:0]  imm;
  logic        load = 1'b0;
  logic [30:0] load_causes;
  logic [7:0]  load_imm;

  assign trap_vector_base = TVB;
  assign {mmu_cause, prot_cause, instr_cause, ctx_cause, bus_cause, assert_cause, system_call_instruction_req, nmi_req} = causes;
  assign system_call_instruction_imm = imm;

  // one-cycle load strobe keeps the causes written by one process only
  task automatic raise(input logic [30:0] c, input logic [7:0] i);
    load_causes <= c;
    load_imm    <= i;
    load        <= 1'b1;
    @(posedge clk);
    load        <= 1'b0;
  endtask

  // causes dropped once consumed; a stale immediate must not look valid
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      causes <= '0;
      imm <= 8'h5A;
    end else if (load) begin
      causes <= load_causes;
      imm <= load_imm;
    end else if (trap_ack) begin
      causes <= '0;
      imm <= ~imm;
    end
  end
endmodule // pipeline_model

`default_nettype wire

//--- test_trap_interrupt_vectoring.sv
/*
  Self-checking bench of the vectoring block: base register, interrupt entry
  and trap classification, with the pipeline model on the cause side.
  Assumes: design files and pipeline_model compiled first.
*/
`timescale 1ns/100ps
`default_nettype none

module test_trap_interrupt_vectoring;
  import trap_vectoring_pkg::*;

  localparam logic [31:0] TVB = 32'h0000_4000;
  logic clk, nrst, csr_write, csr_read, int_accept;
  logic [15:0] csr_addr;
  logic [31:0] csr_wdata, csr_rdata, trap_vector_base, fetch_addr, rd;
  logic csr_hit, hit, trap_ack, gpr15_we, trap_synchronous, trap_hardware;
  logic fetch_redirect, fetch_is_trap, busy, system_call_instruction_req, nmi_req;
  prio_t pending_priority_number;
  trap_class_t trap_class_index;
  logic [7:0] trap_ident_number, system_call_instruction_imm;
  logic [1:0] mmu_cause, assert_cause;
  logic [6:0] prot_cause, ctx_cause;
  logic [4:0] instr_cause;
  logic [5:0] bus_cause;
  int miscompares = 0;
  int n_compared = 0;

  trap_interrupt_vectoring DUT (.clk(clk), .nrst(nrst), .csr_addr(csr_addr), .csr_write(csr_write),
    .csr_read(csr_read), .csr_wdata(csr_wdata), .csr_rdata(csr_rdata), .csr_hit(csr_hit),
    .pending_priority_number(pending_priority_number), .int_accept(int_accept),
    .trap_vector_base(trap_vector_base), .mmu_cause(mmu_cause), .prot_cause(prot_cause),
    .instr_cause(instr_cause), .ctx_cause(ctx_cause), .bus_cause(bus_cause), .assert_cause(assert_cause),
    .system_call_instruction_req(system_call_instruction_req), .system_call_instruction_imm(system_call_instruction_imm), .nmi_req(nmi_req), .trap_ack(trap_ack),
    .gpr15_we(gpr15_we), .trap_ident_number(trap_ident_number), .trap_class_index(trap_class_index),
    .trap_synchronous(trap_synchronous), .trap_hardware(trap_hardware), .fetch_redirect(fetch_redirect),
    .fetch_addr(fetch_addr), .fetch_is_trap(fetch_is_trap), .busy(busy));

  pipeline_model #(.TVB(TVB)) pipe (.clk(clk), .nrst(nrst), .trap_ack(trap_ack),
    .trap_vector_base(trap_vector_base), .mmu_cause(mmu_cause), .prot_cause(prot_cause),
    .instr_cause(instr_cause), .ctx_cause(ctx_cause), .bus_cause(bus_cause), .assert_cause(assert_cause),
    .system_call_instruction_req(system_call_instruction_req), .system_call_instruction_imm(system_call_instruction_imm), .nmi_req(nmi_req));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic test_done();
    if (miscompares == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] t=%0t got %h exp %h", $time, g, e);
    end
  endtask

  task automatic csr_wr(input logic [15:0] a, input logic [31:0] d);
    @(posedge clk);
    csr_addr <= a;
    csr_wdata <= d;
    csr_write <= 1'b1;
    @(posedge clk);
    csr_write <= 1'b0;
  endtask

  task automatic csr_rd(input logic [15:0] a, output logic [31:0] d, output logic h);
    @(posedge clk);
    csr_addr <= a;
    csr_read <= 1'b1;
    @(posedge clk);
    csr_read <= 1'b0;
    #1;
    d = csr_rdata;
    h = csr_hit;
  endtask

  // reset value, reserved bit, unmapped place
  task automatic base_register();
    csr_rd(16'hFE20, rd, hit);
    chk(rd, 32'h0000_0000);
    csr_wr(16'hFE20, 32'hFFFF_FFFF);
    csr_rd(16'hFE20, rd, hit);
    chk(rd, 32'hFFFF_FFFE);
    chk(hit, 1'b1);
    csr_wr(16'hFE20, 32'h0000_2000);
    csr_wr(16'hFE24, 32'h1234_5678);
    csr_rd(16'hFE24, rd, hit);
    chk(rd, 32'h0000_0000);
    chk(hit, 1'b0);
    csr_rd(16'hFE20, rd, hit);
    chk(rd, 32'h0000_2000);
  endtask

  // priority moves right after acceptance; entry must keep the accepted one
  task automatic int_case(input prio_t p, input logic [31:0] exp);
    int i;
    @(posedge clk);
    int_accept <= 1'b1;
    pending_priority_number <= p;
    @(posedge clk);
    int_accept <= 1'b0;
    pending_priority_number <= ~p;
    for (i = 0; i < 6 && fetch_redirect !== 1'b1; i++) begin
      @(posedge clk);
      #1;
    end
    chk(fetch_redirect, 1'b1);
    chk(fetch_addr, exp);
    chk(fetch_is_trap, 1'b0);
  endtask

  task automatic int_zero();
    int i;
    logic seen;
    seen = 1'b0;
    @(posedge clk);
    int_accept <= 1'b1;
    pending_priority_number <= 8'h00;
    @(posedge clk);
    int_accept <= 1'b0;
    for (i = 0; i < 5; i++) begin
      @(posedge clk);
      #1;
      seen = seen | fetch_redirect;
    end
    chk(seen, 1'b0);
  endtask

  task automatic trap_case(input logic [30:0] c, input logic [7:0] i8, input logic [2:0] cls,
                           input logic [7:0] ident, input logic syn, input logic hw);
    int i;
    @(posedge clk);
    pipe.raise(c, i8);
    for (i = 0; i < 6 && gpr15_we !== 1'b1; i++) begin
      @(posedge clk);
      #1;
    end
    chk(gpr15_we, 1'b1);
    chk(trap_ack, 1'b1);
    chk(busy, 1'b1);
    chk(trap_ident_number, ident);
    chk(trap_class_index, cls);
    chk({trap_synchronous, trap_hardware}, {syn, hw});
    @(posedge clk);
    #1;
    chk(fetch_redirect, 1'b1);
    chk(fetch_addr, TVB | (32'(cls) << 5));
    chk(fetch_is_trap, 1'b1);
  endtask

  initial begin
    nrst = 1'b0;
    csr_addr = 16'h0000;
    csr_write = 1'b0;
    csr_read = 1'b0;
    csr_wdata = 32'h0000_0000;
    int_accept = 1'b0;
    pending_priority_number = 8'h00;
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    base_register();
    int_case(8'hFF, 32'h0000_3FE0);
    int_case(8'h01, 32'h0000_2020);
    int_zero();
    trap_case(31'h1 << 29, 8'h00, 3'h0, 8'h00, 1'b1, 1'b1);
    trap_case(31'h1 << 30, 8'h00, 3'h0, 8'h01, 1'b1, 1'b1);
    trap_case(31'h3 << 29, 8'h00, 3'h0, 8'h00, 1'b1, 1'b1);
    trap_case(31'h0A << 22, 8'h00, 3'h1, 8'h02, 1'b1, 1'b1);
    trap_case(31'h1 << 28, 8'h00, 3'h1, 8'h07, 1'b1, 1'b1);
    trap_case(31'h1 << 17, 8'h00, 3'h2, 8'h01, 1'b1, 1'b1);
    trap_case(31'h1 << 21, 8'h00, 3'h2, 8'h05, 1'b1, 1'b1);
    trap_case(31'h1 << 13, 8'h00, 3'h3, 8'h04, 1'b1, 1'b1);
    trap_case(31'h1 << 16, 8'h00, 3'h3, 8'h07, 1'b1, 1'b1);
    trap_case(31'h1 << 6, 8'h00, 3'h4, 8'h03, 1'b0, 1'b1);
    trap_case(31'h1 << 8, 8'h00, 3'h4, 8'h05, 1'b1, 1'b1);
    trap_case(31'h1 << 9, 8'h00, 3'h4, 8'h06, 1'b0, 1'b1);
    trap_case(31'h1 << 2, 8'h00, 3'h5, 8'h01, 1'b1, 1'b0);
    trap_case(31'h1 << 3, 8'h00, 3'h5, 8'h02, 1'b1, 1'b0);
    trap_case(31'h1 << 1, 8'hFF, 3'h6, 8'hFF, 1'b1, 1'b0);
    trap_case(31'h1 << 1, 8'h00, 3'h6, 8'h00, 1'b1, 1'b0);
    trap_case(31'h1, 8'h00, 3'h7, 8'h00, 1'b0, 1'b1);
    test_done();
  end

  // whole run is well under 300 cycles
  initial begin
    #(3000 * 100);
    miscompares++;
    test_done();
  end
endmodule // test_trap_interrupt_vectoring

`default_nettype wire

//--- trap_interrupt_vectoring.sv
/*
  Interrupt and trap vectoring of the core: interrupt vector base register,
  trap classification and identification, D15 write and fetch redirect.
  Assumes: the pipeline holds each trap cause until trap_ack, every input is
  on clk, and the trap vector base register is kept elsewhere in the core.
*/
`timescale 1ns/100ps
`default_nettype none

`include "trap_vectoring_regs.svh"

module trap_interrupt_vectoring
  import trap_vectoring_pkg::*;
#(
  parameter logic [31:0] IVB_RESET_VALUE = `IVB_RESET
) (
  input  wire logic                            clk,
  input  wire logic                            nrst,
  input  wire logic [15:0]                     csr_addr,
  input  wire logic                            csr_write,
  input  wire logic                            csr_read,
  input  wire logic [31:0]                     csr_wdata,
  output logic      [31:0]                     csr_rdata,
  output logic                                 csr_hit,
  input  wire trap_vectoring_pkg::prio_t       pending_priority_number,
  input  wire logic                            int_accept,
  input  wire logic [31:0]                     trap_vector_base,
  input  wire logic [1:0]                      mmu_cause,
  input  wire logic [6:0]                      prot_cause,
  input  wire logic [4:0]                      instr_cause,
  input  wire logic [6:0]                      ctx_cause,
  input  wire logic [5:0]                      bus_cause,
  input  wire logic [1:0]                      assert_cause,
  input  wire logic                            system_call_instruction_req,
  input  wire logic [7:0]                      system_call_instruction_imm,
  input  wire logic                            nmi_req,
  output logic                                 trap_ack,
  output logic                                 gpr15_we,
  output logic      [7:0]                      trap_ident_number,
  output trap_vectoring_pkg::trap_class_t      trap_class_index,
  output logic                                 trap_synchronous,
  output logic                                 trap_hardware,
  output logic                                 fetch_redirect,
  output logic      [31:0]                     fetch_addr,
  output logic                                 fetch_is_trap,
  output logic                                 busy
);
  import trap_vectoring_pkg::*;

  // index of lowest set bit; lowest identification wins
  function automatic logic [2:0] first_set(input logic [6:0] v);
    logic [2:0] idx;
    idx = 3'h0;
    for (int i = 6; i >= 0; i--) begin
      if (v[i]) begin
        idx = 3'(i);
      end
    end
    return idx;
  endfunction

  logic [31:0] interrupt_vector_base;
  logic [31:0] next_ivb;
  logic [31:0] next_rdata;
  logic        next_hit;
  logic        ivb_sel;

  vec_state_t  state;
  vec_state_t  next_state;
  logic        int_pend;
  logic        next_int_pend;
  prio_t       int_prio;
  prio_t       next_int_prio;
  logic [31:0] next_fetch_addr;
  logic        next_is_trap;
  logic [7:0]  next_ident;
  trap_class_t next_class;
  logic        next_sync;
  logic        next_hw;

  logic        any_trap;
  trap_class_t sel_class;
  logic [7:0]  sel_ident;
  logic [31:0] int_entry;
  logic [31:0] trap_entry;

  // register access over the core special register port
  assign ivb_sel = (csr_addr == `IVB_OFFSET);

  always_comb begin
    next_ivb   = interrupt_vector_base;
    next_rdata = csr_rdata;
    next_hit   = csr_hit;
    if (csr_write && ivb_sel) begin
      next_ivb = csr_wdata & `IVB_RSVD_MASK;
    end
    if (csr_read) begin
      next_rdata = ivb_sel ? interrupt_vector_base : 32'h0000_0000;
      next_hit   = ivb_sel;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      interrupt_vector_base <= IVB_RESET_VALUE & `IVB_RSVD_MASK;
      csr_rdata             <= 32'h0000_0000;
      csr_hit               <= 1'b0;
    end else begin
      interrupt_vector_base <= next_ivb;
      csr_rdata             <= next_rdata;
      csr_hit               <= next_hit;
    end
  end

  // trap selection: no enable input exists, so nothing can mask a trap
  assign any_trap = (|mmu_cause) | (|prot_cause) | (|instr_cause) | (|ctx_cause)
                  | (|bus_cause) | (|assert_cause) | system_call_instruction_req | nmi_req;

  // lower class number first; within a class the lowest identification
  always_comb begin
    sel_class = `CLS_NMI;
    sel_ident = `IDENT_NMI;
    if (|mmu_cause) begin
      sel_class = `CLS_MMU;
      sel_ident = `IDENT_BASE_MMU + {5'h00, first_set({5'h00, mmu_cause})};
    end else if (|prot_cause) begin
      sel_class = `CLS_PROT;
      sel_ident = `IDENT_BASE_OTHER + {5'h00, first_set(prot_cause)};
    end else if (|instr_cause) begin
      sel_class = `CLS_INSTR;
      sel_ident = `IDENT_BASE_OTHER + {5'h00, first_set({2'h0, instr_cause})};
    end else if (|ctx_cause) begin
      sel_class = `CLS_CTX;
      sel_ident = `IDENT_BASE_OTHER + {5'h00, first_set(ctx_cause)};
    end else if (|bus_cause) begin
      sel_class = `CLS_BUS;
      sel_ident = `IDENT_BASE_OTHER + {5'h00, first_set({1'b0, bus_cause})};
    end else if (|assert_cause) begin
      sel_class = `CLS_ASSERT;
      sel_ident = `IDENT_BASE_OTHER + {5'h00, first_set({5'h00, assert_cause})};
    end else if (system_call_instruction_req) begin
      sel_class = `CLS_SYSTEM_CALL_INSTRUCTION;
      sel_ident = system_call_instruction_imm;
    end
  end

  vector_entry_former #(
    .INDEX_W (8)
  ) u_int_entry (
    .base  (interrupt_vector_base),
    .index (int_prio),
    .entry (int_entry)
  );

  vector_entry_former #(
    .INDEX_W (3)
  ) u_trap_entry (
    .base  (trap_vector_base),
    .index (sel_class),
    .entry (trap_entry)
  );

  // sequencer: idle -> ident (D15 write) -> fetch for traps, idle -> fetch for interrupts
  always_comb begin
    next_state      = state;
    next_int_pend   = int_pend;
    next_int_prio   = int_prio;
    next_fetch_addr = fetch_addr;
    next_is_trap    = fetch_is_trap;
    next_ident      = trap_ident_number;
    next_class      = trap_class_index;
    next_sync       = trap_synchronous;
    next_hw         = trap_hardware;
    unique case (state)
      st_idle: begin
        if (any_trap) begin
          next_state      = st_ident;
          next_fetch_addr = trap_entry;
          next_is_trap    = 1'b1;
          next_ident      = sel_ident;
          next_class      = sel_class;
          next_sync       = !((sel_class == `CLS_NMI) || ((sel_class == `CLS_BUS) &&
                            ((sel_ident == `IDENT_BUS_ASYNC_DATA) || (sel_ident == `IDENT_BUS_ASYNC_COPROC) ||
                             (sel_ident == `IDENT_BUS_ASYNC_INTEGRITY))));
          next_hw         = !((sel_class == `CLS_ASSERT) || (sel_class == `CLS_SYSTEM_CALL_INSTRUCTION));
        end else if (int_pend) begin
          next_state      = st_fetch;
          next_fetch_addr = int_entry;
          next_is_trap    = 1'b0;
          next_int_pend   = 1'b0;
        end
      end
      st_ident: next_state = st_fetch;
      st_fetch: next_state = st_idle;
    endcase
    // a new acceptance wins over the serve of the previous one
    if (int_accept && (pending_priority_number != `PRIO_NONE)) begin
      next_int_pend = 1'b1;
      next_int_prio = pending_priority_number;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state             <= st_idle;
      int_pend          <= 1'b0;
      int_prio          <= `PRIO_NONE;
      fetch_addr        <= 32'h0000_0000;
      fetch_is_trap     <= 1'b0;
      trap_ident_number <= 8'h00;
      trap_class_index  <= 3'h0;
      trap_synchronous  <= 1'b0;
      trap_hardware     <= 1'b0;
    end else begin
      state             <= next_state;
      int_pend          <= next_int_pend;
      int_prio          <= next_int_prio;
      fetch_addr        <= next_fetch_addr;
      fetch_is_trap     <= next_is_trap;
      trap_ident_number <= next_ident;
      trap_class_index  <= next_class;
      trap_synchronous  <= next_sync;
      trap_hardware     <= next_hw;
    end
  end

  assign gpr15_we       = (state == st_ident);
  assign trap_ack       = (state == st_ident);
  assign fetch_redirect = (state == st_fetch);
  assign busy           = (state != st_idle);

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  a_ivb_write_ok: assert property (csr_write && ivb_sel |=> interrupt_vector_base == ($past(csr_wdata) & `IVB_RSVD_MASK))
    else $error("base register write not stored as masked value");
  a_ivb_bit_zero: assert property (csr_hit |-> csr_rdata[0] == 1'b0)
    else $error("reserved base bit reads nonzero");
  a_trap_not_masked: assert property (state == st_idle && any_trap |=> gpr15_we ##1 fetch_redirect && fetch_is_trap)
    else $error("trap not taken from idle");
  a_ident_before_fetch: assert property (gpr15_we |=> fetch_redirect && fetch_is_trap)
    else $error("D15 write not followed by handler fetch");
  a_trap_entry_addr: assert property (fetch_redirect && fetch_is_trap |->
      fetch_addr == ($past(trap_vector_base, 2) | {26'h0, trap_class_index, 3'h0} << 2))
    else $error("trap entry address wrong");
  a_int_entry_addr: assert property (fetch_redirect && !fetch_is_trap |->
      fetch_addr == ($past(interrupt_vector_base) | {16'h0, $past(int_prio), 8'h00} >> 3))
    else $error("interrupt entry address wrong");
  a_int_prio_valid: assert property (fetch_redirect && !fetch_is_trap |-> $past(int_prio) != `PRIO_NONE)
    else $error("vector fetched for priority zero");
  a_prio_captured: assert property (int_accept && pending_priority_number != `PRIO_NONE |=>
      int_pend && int_prio == $past(pending_priority_number))
    else $error("accepted priority not captured");
  a_mmu_encoder: assert property (state == st_idle && mmu_cause == 2'h3 |=> trap_ident_number == `IDENT_BASE_MMU)
    else $error("memory management encoder priority wrong");
  a_nmi_class: assert property (gpr15_we && trap_class_index == `CLS_NMI |->
      trap_ident_number == `IDENT_NMI && !trap_synchronous && trap_hardware)
    else $error("nmi identification or type wrong");
  a_system_call_instruction_ident: assert property (gpr15_we && trap_class_index == `CLS_SYSTEM_CALL_INSTRUCTION |->
      trap_ident_number == $past(system_call_instruction_imm) && !trap_hardware)
    else $error("system_call_instruction identification not from immediate");

  c_int_fetch:  cover property (fetch_redirect && !fetch_is_trap);
  c_trap_fetch: cover property (fetch_redirect && fetch_is_trap);
  c_system_call_instruction:    cover property (gpr15_we && trap_class_index == `CLS_SYSTEM_CALL_INSTRUCTION);
  c_nmi:        cover property (gpr15_we && trap_class_index == `CLS_NMI);

endmodule // trap_interrupt_vectoring

`default_nettype wire

//--- trap_vectoring_pkg.sv
/*
  Types shared by the vectoring block.
  Assumes: compiled before the design modules.
*/
package trap_vectoring_pkg;

  typedef enum logic [1:0] {st_idle, st_ident, st_fetch} vec_state_t;

  typedef logic [2:0] trap_class_t;
  typedef logic [7:0] prio_t;

endpackage

//--- trap_vectoring_regs.svh
/*
  Register offsets, field positions, reset values and codes of the
  interrupt and trap vectoring block.
  Assumes: included by bare name wherever one of these constants is used.
*/
`ifndef TRAP_VECTORING_REGS_SVH
`define TRAP_VECTORING_REGS_SVH

// core special register address of the interrupt vector base
`define IVB_OFFSET        16'hFE20
// base register bit 0 is reserved and reads as zero
`define IVB_RSVD_MASK     32'hFFFF_FFFE
`define IVB_RESET         32'h0000_0000

// entry spacing: 8 words = 32 bytes
`define VEC_SHIFT         5

`define PRIO_NONE         8'h00

`define CLS_MMU           3'h0
`define CLS_PROT          3'h1
`define CLS_INSTR         3'h2
`define CLS_CTX           3'h3
`define CLS_BUS           3'h4
`define CLS_ASSERT        3'h5
`define CLS_SYSTEM_CALL_INSTRUCTION       3'h6
`define CLS_NMI           3'h7

// first identification number of each cause vector
`define IDENT_BASE_MMU    8'h00
`define IDENT_BASE_OTHER  8'h01
`define IDENT_NMI         8'h00

// asynchronous bus class causes
`define IDENT_BUS_ASYNC_DATA      8'h03
`define IDENT_BUS_ASYNC_COPROC    8'h04
`define IDENT_BUS_ASYNC_INTEGRITY 8'h06

`endif

//--- vector_entry_former.sv
/*
  Forms a vector table entry address: base ORed with index shifted left.
  Assumes: base alignment is the software's duty; overlapping bits are ORed.
*/
`timescale 1ns/100ps
`default_nettype none

`include "trap_vectoring_regs.svh"

module vector_entry_former #(
  parameter int INDEX_W = 8
) (
  input  wire logic [31:0]        base,
  input  wire logic [INDEX_W-1:0] index,
  output logic      [31:0]        entry
);

  logic [31:0] shifted;

  assign shifted = {{(32-INDEX_W-`VEC_SHIFT){1'b0}}, index, {`VEC_SHIFT{1'b0}}};
  assign entry   = base | shifted;

endmodule // vector_entry_former

`default_nettype wire
